// ===== hw/mcor_pkg.sv
package mcor_pkg;
    // Register indices, byte address is four times the index (index == printed offset, not all multiples of 4)
    localparam logic [7:0] REG_R2_OFFSET_IDX   = 8'h72;
    localparam logic [7:0] REG_CFG2_IDX        = 8'h73;
    localparam logic [7:0] REG_ALERT_MASK1_IDX = 8'h74;
    localparam logic [7:0] REG_CFG1_IDX        = 8'h40;
    localparam logic [7:0] REG_CFG4_IDX        = 8'h7D;
    localparam logic [7:0] REG_CFG5_IDX        = 8'h7C;
    localparam logic [7:0] REG_SPEED_SENSE_INPUT_1_MINH_IDX  = 8'h55;
    // Reset values
    localparam logic [7:0] R2_OFFSET_RST   = 8'h00;
    localparam logic [7:0] CFG2_RST        = 8'h00;
    localparam logic [7:0] ALERT_MASK1_RST = 8'h00;
    localparam logic [7:0] CFG1_RST        = 8'h00;
    localparam logic [7:0] CFG4_RST        = 8'h00;
    localparam logic [7:0] CFG5_RST        = 8'h00;
    localparam logic [7:0] SPEED_SENSE_INPUT_1_MINH_RST  = 8'h00;
    // Field positions
    localparam int CFG1_LOCK_BIT       = 1;
    localparam int CFG2_PRES_EN_BIT    = 0;
    localparam int CFG2_AVG_OFF_BIT    = 4;
    localparam int CFG2_BYPASS_BIT     = 5;
    localparam int CFG2_SINGLE_BIT     = 6;
    localparam int CFG2_RES_BIT        = 7;
    localparam int CFG5_RANGE_BIT      = 1;
    localparam int CFG4_BYP_LSB        = 4;
    localparam int SPEED_SENSE_INPUT_1_SEL_LSB       = 5;
    // Channel select codes
    typedef enum logic [2:0] {
        MCOR_CH_V25   = 3'h0,
        MCOR_CH_VCORE = 3'h1,
        MCOR_CH_VSUP  = 3'h2,
        MCOR_CH_V5    = 3'h3,
        MCOR_CH_V12   = 3'h4,
        MCOR_CH_R1T   = 3'h5,
        MCOR_CH_LT    = 3'h6,
        MCOR_CH_R2T   = 3'h7
    } mcor_chan_t;
endpackage

// ===== hw/mcor_top.sv
// Functional notes
// - Remote 2 offset added to the remote 2 measurement.
// - Config 5 bit 1 selects offset range.
// - Lock bit makes offset, config 2 and config 1 read-only.
// - Presence enable makes bits 3:1 report fans.
// - Bits 3:1 show four-wire fans, read-only.
// - Averaging off bit speeds conversions sixteenfold.
// - Global bypass of four input attenuators.
// - Config 4 bits 7:4 bypass individually.
// - Single-channel bit stops round-robin sequencing.
// - Speed_sense_input_1 min high bits 7:5 select input.
// - Config 2 clears to zero at reset.
`timescale 1ns/1ps
`default_nettype none
// One software register byte; every register of the bank repeats it
module mcor_byte_reg
    import mcor_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Write strobe and data
    input  wire logic       i_wr,
    input  wire logic [7:0] i_d,
    // Stored value
    output logic      [7:0] o_q
);
    logic [7:0] q_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_r <= RST_VAL;
        end else if (i_wr) begin
            q_r <= i_d;
        end
    end
    assign o_q = q_r;
endmodule

module mcor_top
    import mcor_pkg::*;
(
    // Clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_B,
    // Wishbone classic slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [9:0]  I_WB_ADR,
    input  wire logic [31:0] I_WB_DAT,
    input  wire logic [3:0]  I_WB_SEL,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    // Measurement datapath
    input  wire logic [9:0]  I_R2_RAW,
    output logic      [9:0]  O_R2_CORR,
    output logic             O_OFFSET_WIDE,
    // Fan sense
    input  wire logic [2:0]  I_FOUR_WIRE_SENSE,
    // Sequencer controls
    output logic             O_AVERAGING_OFF,
    output logic      [3:0]  O_ATTENUATOR_BYPASS,
    output logic             O_SINGLE_CHANNEL_CONVERT,
    output logic      [2:0]  O_CHANNEL_SELECT,
    output logic             O_LOCKED
);
    logic        rst_s1_r;
    logic        rst_s2_r;
    logic        rst_n;
    logic [7:0]  r2_offset_r;
    logic [7:0]  cfg2_r;
    logic [7:0]  alert_mask1_r;
    logic [7:0]  cfg1_r;
    logic [7:0]  cfg4_r;
    logic [7:0]  cfg5_r;
    logic [7:0]  speed_sense_input_1_minh_r;
    logic [2:0]  found_r;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic [9:0]  corr_r;

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    // Bus decode; byte address is four times the index
    wire        req      = I_WB_CYC && I_WB_STB && !ack_r;
    wire        wr_take  = req && I_WB_WE && I_WB_SEL[0];
    wire        aligned  = (I_WB_ADR[1:0] == 2'b00);
    wire [7:0]  idx      = I_WB_ADR[9:2];
    wire        locked   = cfg1_r[CFG1_LOCK_BIT];
    wire [7:0]  wbyte    = I_WB_DAT[7:0];
    wire        hit_off  = aligned && idx == REG_R2_OFFSET_IDX;
    wire        hit_cfg2 = aligned && idx == REG_CFG2_IDX;
    wire        hit_msk  = aligned && idx == REG_ALERT_MASK1_IDX;
    wire        hit_cfg1 = aligned && idx == REG_CFG1_IDX;
    wire        hit_cfg4 = aligned && idx == REG_CFG4_IDX;
    wire        hit_cfg5 = aligned && idx == REG_CFG5_IDX;
    wire        hit_tach = aligned && idx == REG_SPEED_SENSE_INPUT_1_MINH_IDX;
    wire        wr_off   = wr_take && hit_off && !locked;
    wire        wr_cfg2  = wr_take && hit_cfg2 && !locked;
    wire        wr_cfg1  = wr_take && hit_cfg1 && !locked;
    wire        wr_msk   = wr_take && hit_msk;
    wire        wr_cfg4  = wr_take && hit_cfg4;
    wire        wr_cfg5  = wr_take && hit_cfg5;
    wire        wr_tach  = wr_take && hit_tach;
    // Bits 3:1 never stored; they belong to the sense logic
    wire [7:0]  cfg2_wdat = {wbyte[7:4], 3'h0, wbyte[0]};

    // Detect bits stay zero while presence sensing is off
    wire        pres_en  = cfg2_r[CFG2_PRES_EN_BIT];
    wire [2:0]  found_nxt = pres_en ? I_FOUR_WIRE_SENSE : 3'h0;
    // Read-only bits 3:1 come from the sense logic, never the bus
    wire [7:0]  cfg2_view = {cfg2_r[7:4], found_r, cfg2_r[0]};

    wire [7:0]  rbyte =
        hit_off  ? r2_offset_r   :
        hit_cfg2 ? cfg2_view     :
        hit_msk  ? alert_mask1_r :
        hit_cfg1 ? cfg1_r        :
        hit_cfg4 ? cfg4_r        :
        hit_cfg5 ? cfg5_r        :
        hit_tach ? speed_sense_input_1_minh_r  : 8'h00;

    mcor_byte_reg #(
        .RST_VAL (R2_OFFSET_RST)
    ) u_off_reg (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_wr    (wr_off),
        .i_d     (wbyte),
        .o_q     (r2_offset_r)
    );

    mcor_byte_reg #(
        .RST_VAL (CFG2_RST)
    ) u_cfg2_reg (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_wr    (wr_cfg2),
        .i_d     (cfg2_wdat),
        .o_q     (cfg2_r)
    );

    mcor_byte_reg #(
        .RST_VAL (ALERT_MASK1_RST)
    ) u_msk_reg (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_wr    (wr_msk),
        .i_d     (wbyte),
        .o_q     (alert_mask1_r)
    );

    // Lock is sticky: once set only a reset clears it
    mcor_byte_reg #(
        .RST_VAL (CFG1_RST)
    ) u_cfg1_reg (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_wr    (wr_cfg1),
        .i_d     (wbyte),
        .o_q     (cfg1_r)
    );

    mcor_byte_reg #(
        .RST_VAL (CFG4_RST)
    ) u_cfg4_reg (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_wr    (wr_cfg4),
        .i_d     (wbyte),
        .o_q     (cfg4_r)
    );

    mcor_byte_reg #(
        .RST_VAL (CFG5_RST)
    ) u_cfg5_reg (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_wr    (wr_cfg5),
        .i_d     (wbyte),
        .o_q     (cfg5_r)
    );

    mcor_byte_reg #(
        .RST_VAL (SPEED_SENSE_INPUT_1_MINH_RST)
    ) u_tach_reg (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_wr    (wr_tach),
        .i_d     (wbyte),
        .o_q     (speed_sense_input_1_minh_r)
    );

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            found_r <= 3'h0;
            ack_r   <= 1'b0;
            rdat_r  <= 32'h0000_0000;
        end else begin
            found_r <= found_nxt;
            ack_r   <= req;
            rdat_r  <= req ? {24'h00_0000, rbyte} : 32'h0000_0000;
        end
    end
    assign O_WB_ACK = ack_r;
    assign O_WB_DAT = rdat_r;

    // Offset scaling: narrow range uses 0.5 C steps, wide range 1 C steps
    wire        wide     = cfg5_r[CFG5_RANGE_BIT];
    // Raw code taken as 0.25 C per count; wraps, no saturation
    // Narrow step is half a degree, two raw counts per offset count
    wire [9:0]  off_narrow = {r2_offset_r[7], r2_offset_r, 1'b0};
    wire [9:0]  off_wide   = {r2_offset_r, 2'b00};
    wire [9:0]  off_q      = wide ? off_wide : off_narrow;
    wire [9:0]  corr_nxt = I_R2_RAW + off_q;
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n)
            corr_r <= 10'h000;
        else
            corr_r <= corr_nxt;
    end
    assign O_R2_CORR     = corr_r;
    assign O_OFFSET_WIDE = wide;

    // Sequencer controls
    assign O_AVERAGING_OFF = cfg2_r[CFG2_AVG_OFF_BIT];
    wire   global_byp = cfg2_r[CFG2_BYPASS_BIT];
    assign O_ATTENUATOR_BYPASS =
        {4{global_byp}} | cfg4_r[CFG4_BYP_LSB +: 4];
    assign O_SINGLE_CHANNEL_CONVERT = cfg2_r[CFG2_SINGLE_BIT];
    // Code 111 selects remote 2 temperature
    assign O_CHANNEL_SELECT = speed_sense_input_1_minh_r[SPEED_SENSE_INPUT_1_SEL_LSB +: 3];
    assign O_LOCKED = locked;

    lock_hold_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        $past(locked) |-> $stable(cfg2_r) && $stable(r2_offset_r))
        else $error("locked register changed");

    lock_off_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_take && hit_off && locked |=> r2_offset_r == $past(r2_offset_r))
        else $error("offset written while locked");
    off_write_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_off |=> r2_offset_r == $past(wbyte))
        else $error("offset write lost");
    found_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        !pres_en |=> found_r == 3'h0)
        else $error("detect bits set with sensing off");
    found_track_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        pres_en |=> found_r == $past(I_FOUR_WIRE_SENSE))
        else $error("detect bits do not follow sense");
    cfg2_ro_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        cfg2_r[3:1] == 3'h0)
        else $error("read-only bits stored");
    bypass_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        global_byp |-> O_ATTENUATOR_BYPASS == 4'hF)
        else $error("global bypass not applied");
    ind_byp_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        !global_byp |-> O_ATTENUATOR_BYPASS == cfg4_r[7:4])
        else $error("individual bypass wrong");
    ack_pulse_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        ack_r |=> !ack_r)
        else $error("ack held two cycles");
    corr_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        1'b1 |=> corr_r == $past(corr_nxt))
        else $error("corrected value stale");
    sel_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        O_CHANNEL_SELECT == speed_sense_input_1_minh_r[7:5])
        else $error("channel select mismatch");
    lock_cfg2_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_take && hit_cfg2 && locked |=> cfg2_r == $past(cfg2_r))
        else $error("config written while locked");
    lock_sticky_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        locked |=> locked)
        else $error("lock released without reset");
    cfg2_store_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_cfg2 |=> cfg2_r[7:4] == $past(wbyte[7:4])
            && cfg2_r[0] == $past(wbyte[0]))
        else $error("config write lost");
    avg_set_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_cfg2 |=> O_AVERAGING_OFF == $past(wbyte[4]))
        else $error("averaging control wrong");
    single_set_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_cfg2 |=> O_SINGLE_CHANNEL_CONVERT == $past(wbyte[6]))
        else $error("single channel control wrong");
    glob_byp_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_cfg2 && wbyte[5] |=> O_ATTENUATOR_BYPASS == 4'hF)
        else $error("bypass write not applied");
    sel_set_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_tach |=> O_CHANNEL_SELECT == $past(wbyte[7:5]))
        else $error("channel select write lost");
    wide_set_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wr_cfg5 |=> O_OFFSET_WIDE == $past(wbyte[1]))
        else $error("range select write lost");
    corr_wide_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        wide |=> O_R2_CORR == $past(I_R2_RAW) + {$past(r2_offset_r), 2'b00})
        else $error("wide offset misapplied");
    corr_narrow_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        !wide |=> O_R2_CORR == $past(I_R2_RAW)
            + {$past(r2_offset_r[7]), $past(r2_offset_r), 1'b0})
        else $error("narrow offset misapplied");
    ack_req_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        req |=> O_WB_ACK)
        else $error("request not acknowledged");
    ack_src_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        O_WB_ACK |-> $past(req))
        else $error("ack without request");
    rdat_idle_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        !O_WB_ACK |-> O_WB_DAT == 32'h0000_0000)
        else $error("read data outside ack");
    rd_data_a: assert property (
        @(posedge I_MCLK) disable iff (!rst_n)
        req && !I_WB_WE && hit_off |=> O_WB_DAT[7:0] == $past(r2_offset_r))
        else $error("offset read wrong");
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import mcor_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [9:0]  adr = '0;
    logic [31:0] wdat = '0;
    logic [3:0]  sel = '0;
    logic [9:0]  raw = '0;
    logic [2:0]  sense = '0;
    logic [31:0] rdat;
    logic        ack;
    logic [9:0]  corr;
    logic        wide;
    logic        averaging_off;
    logic [3:0]  byp;
    logic        single;
    logic [2:0]  chsel;
    logic        locked;
    int          failures = 0;
    int          checked = 0;

    mcor_top u_dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat),
        .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_R2_RAW(raw),
        .O_R2_CORR(corr), .O_OFFSET_WIDE(wide), .I_FOUR_WIRE_SENSE(sense),
        .O_AVERAGING_OFF(averaging_off), .O_ATTENUATOR_BYPASS(byp),
        .O_SINGLE_CHANNEL_CONVERT(single), .O_CHANNEL_SELECT(chsel),
        .O_LOCKED(locked));

    always #12.5 clk = ~clk;

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; ack and data sampled at the same edge
    task automatic bus(logic w, logic [7:0] idx, logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            final_report();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(logic [7:0] idx, logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd(logic [7:0] idx, logic [7:0] exp, string name);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        check(name, q, {24'h0, exp});
    endtask

    task automatic t_reset();
        rd(REG_R2_OFFSET_IDX, R2_OFFSET_RST, "offset rst");
        rd(REG_CFG2_IDX, CFG2_RST, "cfg2 rst");
        check("ctl rst", {averaging_off, byp, single, chsel}, '0);
    endtask

    task automatic t_offset();
        wr(REG_R2_OFFSET_IDX, 8'h04);
        raw <= 10'd100;
        repeat (3) @(posedge clk);
        check("corr narrow", corr, 10'd108);
        wr(REG_CFG5_IDX, 8'h02);
        repeat (2) @(posedge clk);
        check("wide", wide, 1'b1);
        check("corr wide", corr, 10'd116);
        wr(REG_R2_OFFSET_IDX, 8'hFC);
        repeat (2) @(posedge clk);
        check("corr neg", corr, 10'd84);
        wr(REG_CFG5_IDX, 8'h00);
        wr(REG_R2_OFFSET_IDX, 8'hFD);
        repeat (2) @(posedge clk);
        check("wide off", wide, 1'b0);
        check("corr odd", corr, 10'd94);
    endtask

    task automatic t_cfg2();
        // These config 2 writes leave bit 7 at zero
        wr(REG_CFG2_IDX, 8'h70);
        check("ctl", {averaging_off, byp, single}, 6'b1_1111_1);
        rd(REG_CFG2_IDX, 8'h70, "cfg2 rb");
        wr(REG_CFG2_IDX, 8'h00);
        wr(REG_CFG4_IDX, 8'h50);
        check("byp single", byp, 4'h5);
    endtask

    task automatic t_select();
        for (int i = 0; i < 8; i++) begin
            wr(REG_SPEED_SENSE_INPUT_1_MINH_IDX, {i[2:0], 5'h00});
            check("chsel", chsel, i[2:0]);
        end
    endtask

    task automatic t_detect();
        sense <= 3'b101;
        wr(REG_CFG2_IDX, 8'h0F);
        repeat (2) @(posedge clk);
        rd(REG_CFG2_IDX, 8'h0B, "detect on");
        wr(REG_CFG2_IDX, 8'h0E);
        rd(REG_CFG2_IDX, 8'h00, "detect off");
        sense <= 3'b000;
    endtask

    task automatic t_unmapped();
        wr(8'hFF, 8'hA5);
        rd(8'hFF, 8'h00, "unmapped");
        wr(REG_ALERT_MASK1_IDX, 8'hA5);
        rd(REG_ALERT_MASK1_IDX, 8'hA5, "mask rb");
    endtask

    // Before the reset test: the lock cannot be undone short of reset
    task automatic t_lock();
        wr(REG_CFG2_IDX, 8'h10);
        wr(REG_CFG1_IDX, 8'h02);
        check("locked", locked, 1'b1);
        wr(REG_R2_OFFSET_IDX, 8'h33);
        rd(REG_R2_OFFSET_IDX, 8'hFD, "offset lk");
        wr(REG_CFG2_IDX, 8'h61);
        rd(REG_CFG2_IDX, 8'h10, "cfg2 lk");
    endtask

    // Reset in mid-run: lock and settings must clear
    task automatic t_rerst();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("unlock", locked, 1'b0);
        rd(REG_CFG2_IDX, CFG2_RST, "cfg2 rerst");
        rd(REG_R2_OFFSET_IDX, R2_OFFSET_RST, "offset rerst");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_offset();
        t_cfg2();
        t_select();
        t_detect();
        t_unmapped();
        t_lock();
        t_rerst();
        final_report();
    end
endmodule
`default_nettype wire
